// ===== pci_target_image_decoder_tb_top.sv
`timescale 1ns/1ps
module pci_target_image_decoder_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, a, seed;
	logic e;
	logic [31:0] v [0:5];
	logic [3:0] cmds [0:9];
	integer n_mismatch = 0;
	integer compares = 0;
	integer t;
	wire frame_n, irdy_n, idsel, devsel_n, devsel_oe_n, cfg_claim, lb_req, lb_write, lb_io;
	wire lb_posted, lb_prefetch, lb_burst_write, lb_big_endian, lb_four_beat;
	wire lb_single_prefetch, lb_hold_busy, lb_image;
	wire [31:0] ad, lb_addr;
	wire [3:0] cbe, lb_tc;
	wire [1:0] devsel_timing, lb_port_width;
	wire [5:0] lb_prefetch_len;
	ptid_pci_mst mst (.pclk(pclk), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel), .ad(ad),
		.cbe(cbe));
	ptid_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pci_frame_n(frame_n), .pci_irdy_n(irdy_n), .pci_idsel(idsel),
		.pci_ad(ad), .pci_cbe(cbe), .pci_devsel_n(devsel_n), .pci_devsel_oe_n(devsel_oe_n),
		.cfg_claim(cfg_claim), .devsel_timing(devsel_timing), .lb_req(lb_req), .lb_addr(lb_addr),
		.lb_tc(lb_tc), .lb_port_width(lb_port_width), .lb_write(lb_write), .lb_io(lb_io),
		.lb_posted(lb_posted), .lb_prefetch(lb_prefetch), .lb_prefetch_len(lb_prefetch_len),
		.lb_burst_write(lb_burst_write), .lb_big_endian(lb_big_endian),
		.lb_four_beat(lb_four_beat), .lb_single_prefetch(lb_single_prefetch),
		.lb_hold_busy(lb_hold_busy), .lb_image(lb_image));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic hit_img(input integer i, input [31:0] x, input [3:0] c);
		logic [15:0] m;
		logic mem, io;
		m = 16'hffff << v[2*i+1][15:12];
		mem = c == 4'h6 || c == 4'h7 || (c >= 4'hc && c != 4'hd);
		io = c == 4'h2 || c == 4'h3;
		return v[2*i+1][0] && (((x[31:16] ^ v[2*i][31:16]) & m) == 16'h0)
			&& (v[2*i+1][1] ? io : mem);
	endfunction
	function automatic logic [63:0] expv(input integer i, input [31:0] x, input [3:0] c);
		logic [15:0] m;
		logic [31:0] r;
		logic w;
		m = 16'hffff << v[2*i+1][15:12];
		r = v[2*i+1];
		w = c == 4'h3 || c == 4'h7 || c == 4'hf;
		return {10'h0, i[0], (v[2*i][15:0] & m) | (x[31:16] & ~m), x[15:0], r[11:8], r[7:6],
			w, r[1], w & r[2], ~w & r[3],
			(i == 1 && v[5][6]) ? v[5][5:0] : v[4][5:0], w & r[4], v[4][6] ^ r[5],
			v[5][7], v[5][8], v[5][9]};
	endfunction
	task chk(input string nm, input [63:0] seen, input [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input w, input [11:0] ad_r, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad_r;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task setup(input ov);
		for (int i = 0; i < 2; i++) begin
			v[2*i+1] = rnd() & 32'h0000ffff;
			v[2*i] = rnd() & {16'hffff << v[2*i+1][15:12], 16'hffff};
		end
		v[4] = rnd() & 32'h7f;
		v[5] = rnd() & 32'h3ff;
		if (ov) begin
			v[1][0] = 1'b1;
			v[3] = {v[3][31:16], v[1][15:12], v[3][11:2], v[1][1], 1'b1};
			v[2] = {v[0][31:16], v[2][15:0]};
		end
		for (int j = 0; j < 6; j++)
			apb(1'b1, j * 4, v[j]);
		for (int j = 0; j < 6; j++) begin
			apb(1'b0, j * 4, 32'h0);
			chk("register", q, v[j]);
		end
	endtask
	task pci(input [31:0] x, input [3:0] c);
		logic h0, h1, cs;
		integer n;
		logic [63:0] sv;
		h0 = hit_img(0, x, c);
		h1 = hit_img(1, x, c);
		n = 0;
		cs = 0;
		sv = 0;
		fork
			mst.cycle(x, c, c[3:1] == 3'h5, 4 + rnd() % 4);
			repeat (16) begin
				@(posedge pclk);
				#1;
				if (lb_req === 1'b1) begin
					n++;
					chk("devsel", {devsel_n, devsel_oe_n}, 2'h0);
					sv = {10'h0, lb_image, lb_addr, lb_tc, lb_port_width, lb_write, lb_io, lb_posted,
						lb_prefetch, lb_prefetch_len, lb_burst_write, lb_big_endian, lb_four_beat,
						lb_single_prefetch, lb_hold_busy};
				end
				if (cfg_claim === 1'b1)
					cs = 1;
			end
		join
		chk("claims", {cs, n[3:0]}, {c[3:1] == 3'h5 && x[1:0] == 2'h0, 3'h0, h0 | h1});
		if (h0 | h1)
			chk("local", sv, expv(h0 ? 0 : 1, x, c));
	endtask
	task finish_test;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		#400000;
		n_mismatch++;
		finish_test;
	end
	initial begin
		seed = 32'd61;
		cmds = '{4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'he, 4'hf, 4'h0};
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h018, 32'h0);
		chk("status", q[1:0], 2'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", {e, q}, {1'b1, 32'h0});
		for (t = 0; t < 60; t++) begin
			if (t % 10 == 0)
				setup(t == 0);
			a = rnd();
			if (a[31])
				a[31:16] = v[2*a[2]][31:16] ^ (a[23:16] & {8{a[30]}});
			pci(a, cmds[rnd() % 10]);
		end
		finish_test;
	end
endmodule // pci_target_image_decoder_tb_top
bind ptid_decoder ptid_monitor mon (.pclk(pclk), .presetn(presetn), .pci_frame_n(pci_frame_n),
	.pci_irdy_n(pci_irdy_n), .pci_devsel_n(pci_devsel_n), .cfg_claim(cfg_claim),
	.devsel_timing(devsel_timing), .lb_req(lb_req), .lb_addr(lb_addr), .lb_tc(lb_tc),
	.lb_image(lb_image));

// ===== ptid_decoder.v
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "ptid_regs.vh"

// One target image: hit decision and translated upper address.
// Both images are built from this module, so their hit and translation logic stays equal.
module ptid_image_match #(
	parameter AW = 16,
	parameter SW = 4
) (
	input wire [AW-1:0] match_bits,
	input wire [AW-1:0] remap,
	input wire [SW-1:0] size_code,
	input wire enable,
	input wire io_space,
	input wire [AW-1:0] addr_hi,
	input wire cmd_io,
	input wire cmd_mem,
	output wire hit,
	output wire [AW-1:0] mask,
	output wire [AW-1:0] xlat_hi
);
	wire [AW-1:0] diff;
	wire space_ok;
	wire addr_ok;

	// Each step of the size code drops one more low bit from compare and remap.
	assign mask = {AW{1'b1}} << size_code;
	assign diff = (addr_hi ^ match_bits) & mask;
	assign addr_ok = (diff == {AW{1'b0}});

	// An I/O image answers only I/O commands, a memory image only memory ones.
	assign space_ok = io_space ? cmd_io : cmd_mem;

	// A disabled image never hits, whatever the address.
	assign hit = enable & space_ok & addr_ok;

	// Kept upper bits come from the remap field, the rest pass straight through.
	assign xlat_hi = (remap & mask) | (addr_hi & ~mask);
endmodule // ptid_image_match

module ptid_decoder (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire pci_frame_n,
	input wire pci_irdy_n,
	input wire pci_idsel,
	input wire [31:0] pci_ad,
	input wire [3:0] pci_cbe,
	output reg pci_devsel_n,
	output reg pci_devsel_oe_n,
	output reg cfg_claim,
	output reg [1:0] devsel_timing,
	output reg lb_req,
	output reg [31:0] lb_addr,
	output reg [3:0] lb_tc,
	output reg [1:0] lb_port_width,
	output reg lb_write,
	output reg lb_io,
	output reg lb_posted,
	output reg lb_prefetch,
	output reg [5:0] lb_prefetch_len,
	output reg lb_burst_write,
	output reg lb_big_endian,
	output reg lb_four_beat,
	output reg lb_single_prefetch,
	output reg lb_hold_busy,
	output reg lb_image
);
	reg [31:0] img0_addr_r;
	reg [31:0] img1_addr_r;
	reg [15:0] img0_ctl_r;
	reg [15:0] img1_ctl_r;
	reg [6:0] misc1_r;
	reg [9:0] misc2_r;
	reg [31:0] last_addr_r;
	reg hit_seen_r;
	reg frame_n_r;
	reg irdy_n_r;
	reg frame_prev_r;
	reg [31:0] ad_q1_r;
	reg [3:0] cbe_q1_r;
	reg idsel_q1_r;
	reg busy_r;
	reg [31:0] rd_word;
	wire frame_start;
	wire [3:0] cmd;
	wire is_io;
	wire is_mem;
	wire is_rd;
	wire is_cfg0;
	wire hit0;
	wire hit1;
	wire [15:0] xlat0;
	wire [15:0] xlat1;
	wire [15:0] sel_xlat;
	wire [15:0] sel_ctl;
	wire apb_wr;
	wire apb_rd;
	wire bus_done;
	wire [31:0] lb_addr_nxt;
	wire [3:0] lb_tc_nxt;
	wire [1:0] lb_port_width_nxt;
	wire lb_posted_nxt;
	wire lb_prefetch_nxt;
	wire use_len2;
	wire [5:0] lb_prefetch_len_nxt;
	wire lb_burst_write_nxt;
	wire lb_big_endian_nxt;

	// The PCI pins share pclk with this block, so one register stage is enough.
	// Any deeper filtering would push the claim past the two-clock limit.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_n_r <= 1'b1;
			irdy_n_r <= 1'b1;
			ad_q1_r <= 32'h0;
			cbe_q1_r <= 4'h0;
			idsel_q1_r <= 1'b0;
		end else begin
			frame_n_r <= pci_frame_n;
			irdy_n_r <= pci_irdy_n;
			// Address, command and idsel line up with the registered frame.
			ad_q1_r <= pci_ad;
			cbe_q1_r <= pci_cbe;
			idsel_q1_r <= pci_idsel;
		end
	end

	// The address phase is the first cycle with frame low after it was high.
	assign frame_start = frame_prev_r & ~frame_n_r;
	assign cmd = cbe_q1_r;
	assign is_io = (cmd == `PTID_CMD_IO_RD) | (cmd == `PTID_CMD_IO_WR);
	assign is_mem = (cmd == `PTID_CMD_MEM_RD) | (cmd == `PTID_CMD_MEM_WR) |
		(cmd == `PTID_CMD_MRM) | (cmd == `PTID_CMD_MRL) | (cmd == `PTID_CMD_MWI);
	assign is_rd = (cmd == `PTID_CMD_IO_RD) | (cmd == `PTID_CMD_MEM_RD) |
		(cmd == `PTID_CMD_MRM) | (cmd == `PTID_CMD_MRL);
	// Type 1 cycles have address bits 1:0 set to 01 and are ignored.
	assign is_cfg0 = ((cmd == `PTID_CMD_CFG_RD) | (cmd == `PTID_CMD_CFG_WR)) &
		idsel_q1_r & (ad_q1_r[1:0] == 2'h0);

	// Both images are decoded side by side, each from its own settings.
	ptid_image_match #(
		.AW(16),
		.SW(4)
	) u_img0 (
		.match_bits(img0_addr_r[31:16]),
		.remap(img0_addr_r[15:0]),
		.size_code(img0_ctl_r[`PTID_CTL_SZ_HI:`PTID_CTL_SZ_LO]),
		.enable(img0_ctl_r[`PTID_CTL_EN]),
		.io_space(img0_ctl_r[`PTID_CTL_SPACE]),
		.addr_hi(ad_q1_r[31:16]),
		.cmd_io(is_io),
		.cmd_mem(is_mem),
		.hit(hit0),
		.mask(),
		.xlat_hi(xlat0)
	);

	ptid_image_match #(
		.AW(16),
		.SW(4)
	) u_img1 (
		.match_bits(img1_addr_r[31:16]),
		.remap(img1_addr_r[15:0]),
		.size_code(img1_ctl_r[`PTID_CTL_SZ_HI:`PTID_CTL_SZ_LO]),
		.enable(img1_ctl_r[`PTID_CTL_EN]),
		.io_space(img1_ctl_r[`PTID_CTL_SPACE]),
		.addr_hi(ad_q1_r[31:16]),
		.cmd_io(is_io),
		.cmd_mem(is_mem),
		.hit(hit1),
		.mask(),
		.xlat_hi(xlat1)
	);

	// Image 0 wins when a misprogrammed address hits both images.
	assign sel_xlat = hit0 ? xlat0 : xlat1;
	assign sel_ctl = hit0 ? img0_ctl_r : img1_ctl_r;

	// Translated local request, latched only when a claim is made.
	assign lb_addr_nxt = {sel_xlat, ad_q1_r[15:0]};
	assign lb_tc_nxt = sel_ctl[`PTID_CTL_TC_HI:`PTID_CTL_TC_LO];
	assign lb_port_width_nxt = sel_ctl[`PTID_CTL_PW_HI:`PTID_CTL_PW_LO];

	// Write-only and read-only options are cleared for the other direction.
	assign lb_posted_nxt = ~is_rd & sel_ctl[`PTID_CTL_POSTED_WRITE_ENABLE];
	assign lb_prefetch_nxt = is_rd & sel_ctl[`PTID_CTL_PREFETCH_ENABLE];
	assign lb_burst_write_nxt = ~is_rd & sel_ctl[`PTID_CTL_BWEN];

	// Image 1 may carry its own prefetch length; image 0 always uses the shared one.
	assign use_len2 = ~hit0 & misc2_r[`PTID_M2_PER];
	assign lb_prefetch_len_nxt = use_len2 ? misc2_r[`PTID_M2_PL2_HI:`PTID_M2_PL2_LO] :
		misc1_r[`PTID_M1_PL_HI:`PTID_M1_PL_LO];

	// The flip bit inverts the global byte order for this image only.
	assign lb_big_endian_nxt = misc1_r[`PTID_M1_BO] ^ sel_ctl[`PTID_CTL_FLIP];

	// Claim, translation and settings latch on the address phase.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_prev_r <= 1'b1;
			busy_r <= 1'b0;
			pci_devsel_n <= 1'b1;
			pci_devsel_oe_n <= 1'b1;
			cfg_claim <= 1'b0;
			lb_req <= 1'b0;
			lb_addr <= 32'h0;
			lb_tc <= 4'h0;
			lb_port_width <= 2'h0;
			lb_write <= 1'b0;
			lb_io <= 1'b0;
			lb_posted <= 1'b0;
			lb_prefetch <= 1'b0;
			lb_prefetch_len <= 6'h0;
			lb_burst_write <= 1'b0;
			lb_big_endian <= 1'b0;
			lb_four_beat <= 1'b0;
			lb_single_prefetch <= 1'b0;
			lb_hold_busy <= 1'b0;
			lb_image <= 1'b0;
			last_addr_r <= 32'h0;
			hit_seen_r <= 1'b0;
		end else begin
			frame_prev_r <= frame_n_r;
			lb_req <= 1'b0;
			if (frame_start && !busy_r) begin
				if (hit0 || hit1) begin
					busy_r <= 1'b1;
					pci_devsel_n <= 1'b0;
					pci_devsel_oe_n <= 1'b0;
					lb_req <= 1'b1;
					lb_image <= ~hit0;
					// Every setting is taken once here and held until the next claim.
					lb_addr <= lb_addr_nxt;
					lb_tc <= lb_tc_nxt;
					lb_port_width <= lb_port_width_nxt;
					lb_write <= ~is_rd;
					lb_io <= is_io;
					lb_posted <= lb_posted_nxt;
					lb_prefetch <= lb_prefetch_nxt;
					lb_prefetch_len <= lb_prefetch_len_nxt;
					lb_burst_write <= lb_burst_write_nxt;
					lb_big_endian <= lb_big_endian_nxt;
					lb_four_beat <= misc2_r[`PTID_M2_B4];
					lb_single_prefetch <= misc2_r[`PTID_M2_SING];
					lb_hold_busy <= misc2_r[`PTID_M2_HOLD];
					last_addr_r <= ad_q1_r;
					hit_seen_r <= 1'b1;
				end else if (is_cfg0) begin
					// Config cycles are claimed locally and never raise lb_req.
					busy_r <= 1'b1;
					pci_devsel_n <= 1'b0;
					pci_devsel_oe_n <= 1'b0;
					cfg_claim <= 1'b1;
				end
			end else if (busy_r && frame_n_r && !irdy_n_r) begin
				busy_r <= 1'b1;
			end else if (busy_r && frame_n_r && irdy_n_r) begin
				// Settings stay latched after the transaction ends, until the next claim.
				busy_r <= 1'b0;
				pci_devsel_n <= 1'b1;
				pci_devsel_oe_n <= 1'b1;
				cfg_claim <= 1'b0;
			end
		end
	end

	assign apb_wr = psel & penable & pwrite & pready;
	assign apb_rd = psel & ~penable & ~pwrite;
	assign bus_done = psel & penable & pready;

	// Read data is chosen here and registered on the setup edge.
	always @* begin
		rd_word = 32'h0;
		case (paddr)
		`PTID_ADDR_IMG0_ADDRESS: rd_word = img0_addr_r;
		`PTID_ADDR_IMG0_CONTROL: rd_word = {16'h0, img0_ctl_r};
		`PTID_ADDR_IMG1_ADDRESS: rd_word = img1_addr_r;
		`PTID_ADDR_IMG1_CONTROL: rd_word = {16'h0, img1_ctl_r};
		`PTID_ADDR_MISC_ONE: rd_word = {25'h0, misc1_r};
		`PTID_ADDR_MISC_TWO: rd_word = {22'h0, misc2_r};
		`PTID_ADDR_STATUS: rd_word = {28'h0, hit_seen_r, busy_r, `PTID_DEVSEL_MEDIUM};
		`PTID_ADDR_LAST_ADDR: rd_word = last_addr_r;
		default: rd_word = 32'h0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			img0_addr_r <= 32'h0;
			img1_addr_r <= 32'h0;
			img0_ctl_r <= 16'h0;
			img1_ctl_r <= 16'h0;
			misc1_r <= 7'h0;
			misc2_r <= 10'h0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			devsel_timing <= `PTID_DEVSEL_MEDIUM;
		end else begin
			devsel_timing <= `PTID_DEVSEL_MEDIUM;
			pready <= psel & ~penable;
			if (bus_done) begin
				pready <= 1'b0;
			end
			if (psel && !penable) begin
				pslverr <= 1'b0;
				case (paddr)
				`PTID_ADDR_IMG0_ADDRESS, `PTID_ADDR_IMG0_CONTROL, `PTID_ADDR_IMG1_ADDRESS,
				`PTID_ADDR_IMG1_CONTROL, `PTID_ADDR_MISC_ONE, `PTID_ADDR_MISC_TWO,
				`PTID_ADDR_STATUS, `PTID_ADDR_LAST_ADDR: pslverr <= 1'b0;
				default: pslverr <= 1'b1;
				endcase
			end
			if (apb_rd) begin
				prdata <= rd_word;
			end
			if (apb_wr) begin
				case (paddr)
				`PTID_ADDR_IMG0_ADDRESS: img0_addr_r <= pwdata;
				`PTID_ADDR_IMG0_CONTROL: img0_ctl_r <= pwdata[15:0];
				`PTID_ADDR_IMG1_ADDRESS: img1_addr_r <= pwdata;
				`PTID_ADDR_IMG1_CONTROL: img1_ctl_r <= pwdata[15:0];
				`PTID_ADDR_MISC_ONE: misc1_r <= pwdata[6:0];
				`PTID_ADDR_MISC_TWO: misc2_r <= pwdata[9:0];
				default: img0_addr_r <= img0_addr_r;
				endcase
			end
		end
	end
endmodule // ptid_decoder

// ===== ptid_monitor.sv
`timescale 1ns/1ps
module ptid_monitor (
	input wire pclk,
	input wire presetn,
	input wire pci_frame_n,
	input wire pci_irdy_n,
	input wire pci_devsel_n,
	input wire cfg_claim,
	input wire [1:0] devsel_timing,
	input wire lb_req,
	input wire [31:0] lb_addr,
	input wire [3:0] lb_tc,
	input wire lb_image
);
	reg [3:0] fcnt_r;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Counts cycles since the frame pin went low, so the claim delay can be bounded.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fcnt_r <= 4'h0;
		else if (pci_frame_n)
			fcnt_r <= 4'h0;
		else if (fcnt_r != 4'hf)
			fcnt_r <= fcnt_r + 4'h1;
	end
	sequence idle_s;
		(pci_frame_n && pci_irdy_n) [*7];
	endsequence
	sequence claim_s;
		$fell(pci_devsel_n) ##0 !cfg_claim;
	endsequence
	devsel_medium_a: assert property (devsel_timing == 2'h1)
		else $error("devsel timing code wrong");
	devsel_delay_a: assert property ($fell(pci_devsel_n) |-> fcnt_r inside {[4'h1:4'h2]})
		else $error("devsel came too late after frame");
	idle_release_a: assert property (idle_s |-> pci_devsel_n)
		else $error("devsel held on an idle bus");
	claim_req_a: assert property (claim_s |-> lb_req)
		else $error("image claim without local request");
	req_devsel_a: assert property (lb_req |-> !pci_devsel_n)
		else $error("local request without claim");
	req_single_a: assert property (lb_req |=> !lb_req [*4])
		else $error("more than one local request");
	cfg_local_a: assert property (cfg_claim |-> !lb_req)
		else $error("config cycle forwarded");
	hold_stable_a: assert property (!lb_req |-> $stable(lb_addr) && $stable(lb_tc) && $stable(lb_image))
		else $error("local settings changed mid transaction");
endmodule // ptid_monitor

// ===== ptid_pci_mst.sv
`timescale 1ns/1ps
module ptid_pci_mst (
	input wire pclk,
	output reg frame_n,
	output reg irdy_n,
	output reg idsel,
	output reg [31:0] ad,
	output reg [3:0] cbe
);
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		idsel = 1'b0;
		ad = 32'h0;
		cbe = 4'h0;
	end
	// Holds the address for hold+2 cycles; released lines show the inverse value.
	task cycle(input [31:0] a, input [3:0] c, input s, input integer hold);
		@(posedge pclk);
		frame_n <= 1'b0;
		ad <= a;
		cbe <= c;
		idsel <= s;
		@(posedge pclk);
		irdy_n <= 1'b0;
		repeat (hold) @(posedge pclk);
		frame_n <= 1'b1;
		@(posedge pclk);
		irdy_n <= 1'b1;
		ad <= ~a;
		cbe <= ~c;
		idsel <= ~s;
		repeat (6) @(posedge pclk);
	endtask
endmodule // ptid_pci_mst

// ===== ptid_regs.vh
`ifndef PTID_REGS_VH
`define PTID_REGS_VH
`define PTID_ADDR_IMG0_ADDRESS 12'h000
`define PTID_ADDR_IMG0_CONTROL 12'h004
`define PTID_ADDR_IMG1_ADDRESS 12'h008
`define PTID_ADDR_IMG1_CONTROL 12'h00c
`define PTID_ADDR_MISC_ONE 12'h010
`define PTID_ADDR_MISC_TWO 12'h014
`define PTID_ADDR_STATUS 12'h018
`define PTID_ADDR_LAST_ADDR 12'h01c
`define PTID_CTL_EN 0
`define PTID_CTL_SPACE 1
`define PTID_CTL_POSTED_WRITE_ENABLE 2
`define PTID_CTL_PREFETCH_ENABLE 3
`define PTID_CTL_BWEN 4
`define PTID_CTL_FLIP 5
`define PTID_CTL_PW_LO 6
`define PTID_CTL_PW_HI 7
`define PTID_CTL_TC_LO 8
`define PTID_CTL_TC_HI 11
`define PTID_CTL_SZ_LO 12
`define PTID_CTL_SZ_HI 15
`define PTID_CTL_MASK 32'h0000ffff
`define PTID_M1_PL_LO 0
`define PTID_M1_PL_HI 5
`define PTID_M1_BO 6
`define PTID_M1_MASK 32'h0000007f
`define PTID_M2_PL2_LO 0
`define PTID_M2_PL2_HI 5
`define PTID_M2_PER 6
`define PTID_M2_B4 7
`define PTID_M2_SING 8
`define PTID_M2_HOLD 9
`define PTID_M2_MASK 32'h000003ff
`define PTID_CMD_IO_RD 4'h2
`define PTID_CMD_IO_WR 4'h3
`define PTID_CMD_MEM_RD 4'h6
`define PTID_CMD_MEM_WR 4'h7
`define PTID_CMD_CFG_RD 4'ha
`define PTID_CMD_CFG_WR 4'hb
`define PTID_CMD_MRM 4'hc
`define PTID_CMD_MRL 4'he
`define PTID_CMD_MWI 4'hf
`define PTID_DEVSEL_MEDIUM 2'h1
`define PTID_DEVSEL_DELAY 2'h1
`endif
